// ---- inc/rplex_defines.svh ----
// constants for the remote parameter lexer
// assumes byte-wide ascii characters and a 100 MHz clock
`ifndef RPLEX_DEFINES_SVH
`define RPLEX_DEFINES_SVH
`define RPLEX_CH_CR 8'h0d
`define RPLEX_CH_LF 8'h0a
`define RPLEX_CH_DQ 8'h22
`define RPLEX_CH_SQ 8'h27
`define RPLEX_CH_HASH 8'h23
`define RPLEX_CH_COMMA 8'h2c
`define RPLEX_CH_SEMI 8'h3b
`define RPLEX_CH_SPACE 8'h20
`define RPLEX_CH_PLUS 8'h2b
`define RPLEX_CH_MINUS 8'h2d
`define RPLEX_CH_DOT 8'h2e
`define RPLEX_CH_UNDER 8'h5f
`define RPLEX_ERR_SYNTAX 16'hff9a
`define RPLEX_ERR_HEADER 16'hff92
`define RPLEX_ERR_UNDEF 16'hff8f
`define RPLEX_ERR_NUMCHAR 16'hff87
`define RPLEX_ERR_STRDATA 16'hff6a
`define RPLEX_ERR_STRTERM 16'hff69
`define RPLEX_ERR_STRSPACE 16'hff41
`define RPLEX_ERR_TOKSPACE 16'hff40
`define RPLEX_ERR_PARAM 16'hff24
`define RPLEX_ERR_RANGE 16'hff22
`define RPLEX_ERR_CFGINC 16'hfee2
`define RPLEX_ERR_CFGNA 16'hfee1
`define RPLEX_ERR_CMDNA 16'hfee0
`define RPLEX_ESR_CME_BIT 5
`define RPLEX_ESR_EXE_BIT 4
`define RPLEX_INT_MAX 17'h0ffff
`define RPLEX_FIFO_DEPTH 32
`define RPLEX_TOK_MAX 8'h40
`endif

// ---- inc/rplex_pkg.sv ----
// types for the remote parameter lexer
// assumes rplex_defines.svh is on the include path
package rplex_pkg;
    typedef enum logic [3:0] {
        RPLEX_TK_NONE = 4'h0,
        RPLEX_TK_DQSTR = 4'h1,
        RPLEX_TK_SQSTR = 4'h2,
        RPLEX_TK_WORD = 4'h3,
        RPLEX_TK_FLOAT = 4'h4,
        RPLEX_TK_BIN = 4'h5,
        RPLEX_TK_OCT = 4'h6,
        RPLEX_TK_HEX = 4'h7,
        RPLEX_TK_SEP = 4'h8
    } rplex_kind_e;
    typedef struct packed {
        logic [7:0] data;
        logic eoi;
    } rplex_char_s;
    typedef struct packed {
        rplex_kind_e kind;
        logic last;
        logic [7:0] data;
        logic [15:0] value;
    } rplex_tok_s;
endpackage

// ---- hdl/rplex_top.sv ----
// remote parameter lexer: fifo plus character scanner and error reporter
// assumes characters arrive on the same clock from the serial/gpib front end
//
// Function
// RULE1 - double quote string, doubled quote is literal
// RULE2 - controller sends no cr, lf, eoi in quotes
// RULE3 - flag unclosed or mismatched quoted string
// RULE4 - single quote string same, doubled literal
// RULE5 - word starts letter, then letter digit underscore
// RULE6 - other character ends a word
// RULE7 - number ends at comma semi nl eoi space
// RULE8 - invalid character inside number raises error
// RULE9 - sign, period or digit starts float
// RULE10 - float: sign, int, point, frac, exponent
// RULE11 - hash b binary, unsigned up to 65535
// RULE12 - hash q octal, up to 177777 octal
// RULE13 - hash h hexadecimal, up to ffff
// RULE14 - command errors set status bit 5
// RULE15 - execution errors set status bit 4
// RULE16 - codes -102, -110, -113 for parse faults
// RULE17 - code -121 for bad number character
// RULE18 - codes -150, -151 for string faults
// RULE19 - codes -191, -192 for storage exhaustion
// RULE20 - codes -220, -222 for parameter faults
// RULE21 - codes -286, -287, -288 for config faults
// RULE22 - echo on reports now, off queues errors
`timescale 1ns/10ps
`include "rplex_defines.svh"

module rplex_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic full;
    logic empty;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign empty = (wr_ptr == rd_ptr);
    // pointers after this edge; in_ready is registered from them
    assign next_wr_ptr = wr_ptr + {{AW{1'b0}}, in_valid && !full};
    assign next_rd_ptr = rd_ptr + {{AW{1'b0}}, out_ready && !empty};
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    // storage write
    always_ff @(posedge clock)
    begin
        if (in_valid && !full)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end
    // pointers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            in_ready <= (next_wr_ptr ^ next_rd_ptr) != {1'b1, {AW{1'b0}}}; // not full next cycle
        end
    end
endmodule

module rplex_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire rplex_pkg::rplex_char_s in_char,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic echo_on,
    input wire logic exec_err_valid,
    input wire logic [15:0] exec_err_code,
    input wire logic cmd_err_valid,
    input wire logic [15:0] cmd_err_code,
    input wire logic esr_clear,
    output rplex_pkg::rplex_tok_s tok,
    output logic tok_valid,
    output logic [15:0] err_code,
    output logic err_now,
    output logic err_queued,
    output logic [7:0] esr
);
    typedef enum logic [3:0] {
        RPLEX_ST_IDLE = 4'h0,
        RPLEX_ST_QSTR = 4'h1,
        RPLEX_ST_QEND = 4'h2,
        RPLEX_ST_WORD = 4'h3,
        RPLEX_ST_FINT = 4'h4,
        RPLEX_ST_FFRAC = 4'h5,
        RPLEX_ST_FEXP = 4'h6,
        RPLEX_ST_HASH = 4'h7,
        RPLEX_ST_RADIX = 4'h8,
        RPLEX_ST_SKIP = 4'h9
    } rplex_state_e;

    rplex_state_e state;
    rplex_pkg::rplex_char_s c;
    logic c_valid;
    logic [7:0] ch;
    logic [7:0] quote;
    logic [1:0] radix_sh;
    logic [16:0] acc;
    logic [7:0] tok_count;
    logic is_alpha;
    logic is_digit;
    logic is_hex;
    logic [3:0] dval;
    logic num_end;
    logic parse_err;
    logic [15:0] parse_code;
    rplex_pkg::rplex_kind_e radix_kind;

    rplex_fifo #(.WIDTH(9), .DEPTH(`RPLEX_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .in_data(in_char),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .out_data(c),
        .out_valid(c_valid),
        .out_ready(1'b1)
    );

    // character classes
    assign ch = c.data;
    assign is_alpha = (ch >= 8'h41 && ch <= 8'h5a) || (ch >= 8'h61 && ch <= 8'h7a);
    assign is_digit = (ch >= 8'h30 && ch <= 8'h39);
    assign is_hex = is_digit || (ch >= 8'h41 && ch <= 8'h46) || (ch >= 8'h61 && ch <= 8'h66);
    assign dval = is_digit ? ch[3:0] : 4'(ch[3:0] + 4'h9);
    assign num_end = c.eoi || ch == `RPLEX_CH_COMMA || ch == `RPLEX_CH_SEMI // [RULE7]
        || ch == `RPLEX_CH_LF || ch == `RPLEX_CH_SPACE;
    assign radix_kind = radix_sh == 2'h1 ? rplex_pkg::RPLEX_TK_BIN
        : radix_sh == 2'h3 ? rplex_pkg::RPLEX_TK_OCT : rplex_pkg::RPLEX_TK_HEX;

    // scanner state and token output
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= RPLEX_ST_IDLE;
            quote <= 8'h00;
            radix_sh <= 2'h0;
            acc <= 17'h00000;
            tok <= '0;
            tok_valid <= 1'b0;
            parse_err <= 1'b0;
            parse_code <= 16'h0000;
            tok_count <= 8'h00;
        end
        else
        begin
            tok_valid <= 1'b0;
            parse_err <= 1'b0;
            if (c_valid)
            begin
                tok.data <= ch;
                tok.last <= 1'b0;
                unique case (state)
                    RPLEX_ST_IDLE:
                    begin
                        if (ch == `RPLEX_CH_DQ || ch == `RPLEX_CH_SQ) // [RULE1] [RULE4]
                        begin
                            quote <= ch;
                            state <= RPLEX_ST_QSTR;
                        end
                        else if (is_alpha) // [RULE5]
                        begin
                            tok.kind <= rplex_pkg::RPLEX_TK_WORD;
                            tok_valid <= 1'b1;
                            state <= RPLEX_ST_WORD;
                        end
                        else if (is_digit || ch == `RPLEX_CH_PLUS || ch == `RPLEX_CH_MINUS
                            || ch == `RPLEX_CH_DOT) // [RULE9] [RULE10]
                        begin
                            tok.kind <= rplex_pkg::RPLEX_TK_FLOAT;
                            tok_valid <= 1'b1;
                            state <= ch == `RPLEX_CH_DOT ? RPLEX_ST_FFRAC : RPLEX_ST_FINT;
                        end
                        else if (ch == `RPLEX_CH_HASH)
                            state <= RPLEX_ST_HASH;
                        else if (ch == `RPLEX_CH_COMMA || ch == `RPLEX_CH_SEMI)
                        begin
                            tok.kind <= rplex_pkg::RPLEX_TK_SEP;
                            tok.last <= 1'b1;
                            tok_valid <= 1'b1;
                            tok_count <= ch == `RPLEX_CH_SEMI ? 8'h00 : 8'(tok_count + 8'h01);
                            if (tok_count == `RPLEX_TOK_MAX) // [RULE19]
                            begin
                                parse_err <= 1'b1;
                                parse_code <= `RPLEX_ERR_TOKSPACE;
                            end
                        end
                        else if (ch == `RPLEX_CH_LF || ch == `RPLEX_CH_CR || c.eoi)
                            tok_count <= 8'h00;
                        else if (ch != `RPLEX_CH_SPACE) // [RULE16]
                        begin
                            parse_err <= 1'b1;
                            parse_code <= `RPLEX_ERR_SYNTAX;
                        end
                    end
                    RPLEX_ST_QSTR:
                    begin
                        if (ch == `RPLEX_CH_LF || ch == `RPLEX_CH_CR || c.eoi) // [RULE3] [RULE18]
                        begin
                            parse_err <= 1'b1;
                            parse_code <= `RPLEX_ERR_STRTERM;
                            state <= RPLEX_ST_IDLE;
                        end
                        else if (ch == quote)
                            state <= RPLEX_ST_QEND;
                        else
                        begin
                            tok.kind <= quote == `RPLEX_CH_DQ ? rplex_pkg::RPLEX_TK_DQSTR
                                : rplex_pkg::RPLEX_TK_SQSTR;
                            tok_valid <= 1'b1;
                        end
                    end
                    RPLEX_ST_QEND:
                    begin
                        tok.kind <= quote == `RPLEX_CH_DQ ? rplex_pkg::RPLEX_TK_DQSTR
                            : rplex_pkg::RPLEX_TK_SQSTR;
                        tok_valid <= 1'b1;
                        if (ch == quote) // [RULE1] [RULE4]
                            state <= RPLEX_ST_QSTR;
                        else
                        begin
                            tok.last <= 1'b1; // closing quote: string done, char dropped
                            tok.data <= 8'h00;
                            state <= RPLEX_ST_IDLE;
                            if (is_alpha || is_digit || ch == `RPLEX_CH_DQ || ch == `RPLEX_CH_SQ)
                            begin
                                parse_err <= 1'b1; // [RULE18]
                                parse_code <= `RPLEX_ERR_STRDATA;
                            end
                        end
                    end
                    RPLEX_ST_WORD:
                    begin
                        tok.kind <= rplex_pkg::RPLEX_TK_WORD;
                        tok_valid <= 1'b1;
                        if (!(is_alpha || is_digit || ch == `RPLEX_CH_UNDER)) // [RULE6]
                        begin
                            tok.last <= 1'b1;
                            tok.data <= 8'h00;
                            state <= RPLEX_ST_IDLE;
                            if (!num_end && ch != `RPLEX_CH_CR) // [RULE16]
                            begin
                                parse_err <= 1'b1;
                                parse_code <= `RPLEX_ERR_HEADER;
                            end
                        end
                    end
                    RPLEX_ST_FINT, RPLEX_ST_FFRAC, RPLEX_ST_FEXP:
                    begin
                        tok.kind <= rplex_pkg::RPLEX_TK_FLOAT;
                        tok_valid <= 1'b1;
                        if (num_end)
                        begin
                            tok.last <= 1'b1;
                            tok.data <= 8'h00;
                            state <= RPLEX_ST_IDLE;
                        end
                        else if (is_digit)
                            state <= state;
                        else if (ch == `RPLEX_CH_DOT && state == RPLEX_ST_FINT) // [RULE10]
                            state <= RPLEX_ST_FFRAC;
                        else if ((ch == 8'h45 || ch == 8'h65) && state != RPLEX_ST_FEXP)
                            state <= RPLEX_ST_FEXP;
                        else if ((ch == `RPLEX_CH_PLUS || ch == `RPLEX_CH_MINUS)
                            && state == RPLEX_ST_FEXP)
                            state <= state;
                        else // [RULE8] [RULE17]
                        begin
                            tok_valid <= 1'b0;
                            parse_err <= 1'b1;
                            parse_code <= `RPLEX_ERR_NUMCHAR;
                            state <= RPLEX_ST_SKIP;
                        end
                    end
                    RPLEX_ST_HASH:
                    begin
                        acc <= 17'h00000;
                        state <= RPLEX_ST_RADIX;
                        if (ch == 8'h42 || ch == 8'h62) // [RULE11]
                            radix_sh <= 2'h1;
                        else if (ch == 8'h51 || ch == 8'h71) // [RULE12]
                            radix_sh <= 2'h3;
                        else if (ch == 8'h48 || ch == 8'h68) // [RULE13]
                            radix_sh <= 2'h0;
                        else
                        begin
                            parse_err <= 1'b1; // [RULE17]
                            parse_code <= `RPLEX_ERR_NUMCHAR;
                            state <= RPLEX_ST_SKIP;
                        end
                    end
                    RPLEX_ST_RADIX:
                    begin
                        if (num_end)
                        begin
                            tok.kind <= radix_kind;
                            tok.value <= acc[15:0];
                            tok.last <= 1'b1;
                            tok_valid <= 1'b1;
                            state <= RPLEX_ST_IDLE;
                        end
                        else if ((radix_sh == 2'h1 && (ch == 8'h30 || ch == 8'h31))
                            || (radix_sh == 2'h3 && ch >= 8'h30 && ch <= 8'h37)
                            || (radix_sh == 2'h0 && is_hex))
                        begin
                            acc <= radix_sh == 2'h1 ? {acc[15:0], ch[0]}
                                : radix_sh == 2'h3 ? {acc[13:0], ch[2:0]} : {acc[12:0], dval};
                            if (acc > (`RPLEX_INT_MAX >> (radix_sh == 2'h1 ? 1
                                : radix_sh == 2'h3 ? 3 : 4))) // range check
                            begin
                                parse_err <= 1'b1; // [RULE20]
                                parse_code <= `RPLEX_ERR_RANGE;
                                state <= RPLEX_ST_SKIP;
                            end
                        end
                        else
                        begin
                            parse_err <= 1'b1; // [RULE8] [RULE17]
                            parse_code <= `RPLEX_ERR_NUMCHAR;
                            state <= RPLEX_ST_SKIP;
                        end
                    end
                    RPLEX_ST_SKIP:
                    begin
                        if (num_end)
                            state <= RPLEX_ST_IDLE;
                    end
                    default:
                        state <= RPLEX_ST_IDLE;
                endcase
            end
        end
    end

    // error reporting and status bits; a set in the clear cycle wins
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            err_code <= 16'h0000;
            err_now <= 1'b0;
            err_queued <= 1'b0;
            esr <= 8'h00;
        end
        else
        begin
            err_now <= 1'b0;
            err_queued <= 1'b0;
            if (esr_clear)
                esr <= 8'h00;
            if (parse_err || cmd_err_valid) // [RULE14] [RULE16] [RULE19]
            begin
                err_code <= parse_err ? parse_code : cmd_err_code;
                err_now <= echo_on; // [RULE22]
                err_queued <= !echo_on;
                if (cmd_err_valid || parse_code != `RPLEX_ERR_RANGE)
                    esr[`RPLEX_ESR_CME_BIT] <= 1'b1;
            end
            else if (exec_err_valid) // [RULE15] [RULE20] [RULE21]
            begin
                err_code <= exec_err_code;
                err_now <= echo_on;
                err_queued <= !echo_on;
            end
            // a radix range overflow counts as an execution error
            if (exec_err_valid || (parse_err && parse_code == `RPLEX_ERR_RANGE))
                esr[`RPLEX_ESR_EXE_BIT] <= 1'b1; // [RULE15] [RULE20]
        end
    end

    chk_cmd_err_bit: assert property (@(posedge clock) disable iff (!rst_b) // [RULE14]
        (parse_err && parse_code != `RPLEX_ERR_RANGE) |=> esr[`RPLEX_ESR_CME_BIT])
        else $error("command error bit not set");
    chk_exe_err_bit: assert property (@(posedge clock) disable iff (!rst_b) // [RULE15]
        (exec_err_valid || (parse_err && parse_code == `RPLEX_ERR_RANGE))
        |=> esr[`RPLEX_ESR_EXE_BIT]) else $error("execution bit not set");
    chk_echo_route: assert property (@(posedge clock) disable iff (!rst_b) // [RULE22]
        (parse_err && echo_on) |=> err_now && !err_queued) else $error("echo routing wrong");
    chk_queue_route: assert property (@(posedge clock) disable iff (!rst_b) // [RULE22]
        (parse_err && !echo_on) |=> err_queued && !err_now) else $error("queue routing wrong");
    chk_unterm_str: assert property (@(posedge clock) disable iff (!rst_b) // [RULE3]
        (c_valid && state == RPLEX_ST_QSTR && ch == `RPLEX_CH_LF)
        |=> parse_err && parse_code == `RPLEX_ERR_STRTERM) else $error("unterminated missed");
    chk_dbl_quote: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
        (c_valid && state == RPLEX_ST_QEND && ch == quote) |=> state == RPLEX_ST_QSTR
        && tok_valid && tok.data == quote) else $error("doubled quote lost");
    chk_word_end: assert property (@(posedge clock) disable iff (!rst_b) // [RULE6]
        (c_valid && state == RPLEX_ST_WORD && ch == `RPLEX_CH_SPACE)
        |=> tok.last && state == RPLEX_ST_IDLE) else $error("word not ended");
    chk_num_char: assert property (@(posedge clock) disable iff (!rst_b) // [RULE17]
        (c_valid && state == RPLEX_ST_FINT && is_alpha && ch != 8'h45 && ch != 8'h65)
        |=> parse_err && parse_code == `RPLEX_ERR_NUMCHAR) else $error("bad digit missed");
    chk_float_start: assert property (@(posedge clock) disable iff (!rst_b) // [RULE9]
        (c_valid && state == RPLEX_ST_IDLE && is_digit)
        |=> tok_valid && tok.kind == rplex_pkg::RPLEX_TK_FLOAT) else $error("float missed");
endmodule

// ---- tb/rplex_ctrl_model.sv ----
// controller model: offers a text to the lexer one character at a time
// assumes in_ready is settled one step after each rising edge of clock
`timescale 1ns/10ps
module rplex_ctrl_model (
    input wire logic clock,
    input wire logic in_ready,
    output rplex_pkg::rplex_char_s in_char,
    output logic in_valid
);
    // idle state at time zero
    initial
    begin
        in_char = '0;
        in_valid = 1'b0;
    end

    // hold each character until an edge with in_ready high takes it, waiting at most 64 edges for in_ready
    // callers keep cr and lf out of quotes unless a fault is wanted
    task automatic send(input string s, input bit eoi_end, output bit ok);
        int n;
        ok = 1'b1;
        for (int i = 0; i < s.len(); i++)
        begin
            in_char.data = s[i];
            in_char.eoi = eoi_end && (i == s.len() - 1);
            in_valid = 1'b1;
            n = 0;
            while (!in_ready && n < 64)
            begin
                @(posedge clock);
                #1;
                n++;
            end
            if (!in_ready)
                ok = 1'b0;
            @(posedge clock);
            #1;
        end
        // released line shows the inverse, not a stale character
        in_valid = 1'b0;
        in_char.data = ~in_char.data;
        in_char.eoi = 1'b0;
    endtask
endmodule

// ---- tb/rplex_top_tb.sv ----
// self-checking testbench for the remote parameter lexer
// assumes the design files and the controller model are compiled first
`timescale 1ns/10ps
module rplex_top_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic echo_on = 1'b1;
    logic exec_err_valid = 1'b0, cmd_err_valid = 1'b0, esr_clear = 1'b0;
    logic [15:0] exec_err_code = '0, cmd_err_code = '0;
    rplex_pkg::rplex_char_s in_char;
    rplex_pkg::rplex_tok_s tok;
    logic in_valid, in_ready, tok_valid, err_now, err_queued;
    logic [15:0] err_code;
    logic [7:0] esr;
    int miscompares = 0, n_checks = 0;
    rplex_pkg::rplex_tok_s toks[$];
    logic [16:0] errs[$];

    // 100 MHz clock
    always #5 clock = ~clock;

    rplex_top dut_u (.clock(clock), .rst_b(rst_b), .in_char(in_char), .in_valid(in_valid),
        .in_ready(in_ready), .echo_on(echo_on), .exec_err_valid(exec_err_valid),
        .exec_err_code(exec_err_code), .cmd_err_valid(cmd_err_valid),
        .cmd_err_code(cmd_err_code), .esr_clear(esr_clear), .tok(tok),
        .tok_valid(tok_valid), .err_code(err_code), .err_now(err_now),
        .err_queued(err_queued), .esr(esr));
    rplex_ctrl_model ctrl_u (.clock(clock), .in_ready(in_ready), .in_char(in_char),
        .in_valid(in_valid));

    // collect one-cycle token and error pulses
    always @(posedge clock)
    begin
        if (tok_valid === 1'b1) toks.push_back(tok);
        if (err_now === 1'b1 || err_queued === 1'b1) errs.push_back({err_now, err_code});
    end

    // compare one value and count it
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // send a text and let the pipeline drain
    task automatic run(input string s);
        bit ok;
        toks.delete();
        errs.delete();
        ctrl_u.send(s, 1'b0, ok);
        check("char accepted", 1, ok);
        repeat (6) @(posedge clock);
        #1;
    endtask

    task automatic next_tok(output rplex_pkg::rplex_tok_s t);
        t = '0;
        if (toks.size() == 0) check("token present", 1, 0);
        else t = toks.pop_front();
    endtask

    // one token per character, then an end marker
    task automatic expect_str(input rplex_pkg::rplex_kind_e k, input string s);
        rplex_pkg::rplex_tok_s t;
        for (int i = 0; i < s.len(); i++)
        begin
            next_tok(t);
            check("token kind", k, t.kind);
            check("token char", s[i], t.data);
        end
        next_tok(t);
        check("token end", 1, t.last);
    endtask

    task automatic expect_num(input rplex_pkg::rplex_kind_e k, input logic [15:0] v, input bit has_v);
        rplex_pkg::rplex_tok_s t;
        next_tok(t);
        check("number kind", k, t.kind);
        check("number end", 1, t.last);
        if (has_v) check("number value", v, t.value);
    endtask

    // first report, status bits, then clear them
    task automatic expect_err(input logic [16:0] code, input logic [7:0] esr_exp);
        check("error count", 1, errs.size());
        if (errs.size() > 0) check("error code", code, errs[0]);
        check("status bits", esr_exp, esr);
        esr_clear = 1'b1;
        @(posedge clock);
        #1;
        esr_clear = 1'b0;
        check("status cleared", 0, esr);
    endtask

    task automatic t_strings;
        run("A1_ w/cm \"a\"\"b\" 'x''y' ");
        expect_str(rplex_pkg::RPLEX_TK_WORD, "A1_");
        expect_str(rplex_pkg::RPLEX_TK_WORD, "w");
        expect_str(rplex_pkg::RPLEX_TK_WORD, "cm");
        expect_str(rplex_pkg::RPLEX_TK_DQSTR, "a\"b");
        expect_str(rplex_pkg::RPLEX_TK_SQSTR, "x'y");
        expect_err({1'b1, 16'hff92}, 8'h20);
        $display("test strings done");
    endtask

    task automatic t_numbers;
        run("-1.2e+0 .12E1 ,#B10000001 #q0201 ;#H7f #hFFFF ");
        expect_str(rplex_pkg::RPLEX_TK_FLOAT, "-1.2e+0");
        expect_str(rplex_pkg::RPLEX_TK_FLOAT, ".12E1");
        expect_num(rplex_pkg::RPLEX_TK_SEP, 0, 0);
        expect_num(rplex_pkg::RPLEX_TK_BIN, 16'h0081, 1);
        expect_num(rplex_pkg::RPLEX_TK_OCT, 16'h0081, 1);
        expect_num(rplex_pkg::RPLEX_TK_SEP, 0, 0);
        expect_num(rplex_pkg::RPLEX_TK_HEX, 16'h007f, 1);
        expect_num(rplex_pkg::RPLEX_TK_HEX, 16'hffff, 1);
        check("no error", 0, errs.size());
        $display("test numbers done");
    endtask

    task automatic t_faults;
        string s;
        s = "";
        repeat (65) s = {s, ","};
        run("#Q9 ");
        expect_err({1'b1, 16'hff87}, 8'h20);
        run("#B10000000000000000 ");
        expect_err({1'b1, 16'hff22}, 8'h10);
        run("\"ab\n");
        expect_err({1'b1, 16'hff69}, 8'h20);
        run("1x ");
        expect_err({1'b1, 16'hff87}, 8'h20);
        run("!");
        expect_err({1'b1, 16'hff9a}, 8'h20);
        run("'a'b ");
        expect_err({1'b1, 16'hff6a}, 8'h20);
        run(s);
        expect_err({1'b1, 16'hff40}, 8'h20);
        $display("test faults done");
    endtask

    task automatic pulse_err(input bit exe, input logic [15:0] code);
        errs.delete();
        exec_err_code = code;
        cmd_err_code = code;
        exec_err_valid = exe;
        cmd_err_valid = !exe;
        @(posedge clock);
        #1;
        exec_err_valid = 1'b0;
        cmd_err_valid = 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic t_reports;
        echo_on = 1'b0;
        pulse_err(1'b1, 16'hff22);
        expect_err({1'b0, 16'hff22}, 8'h10);
        pulse_err(1'b1, 16'hfee0);
        expect_err({1'b0, 16'hfee0}, 8'h10);
        echo_on = 1'b1;
        pulse_err(1'b0, 16'hff8f);
        expect_err({1'b1, 16'hff8f}, 8'h20);
        $display("test reports done");
    endtask

    // print counts and the verdict, then stop
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // cut a hang short
    initial
    begin
        #500000;
        miscompares++;
        give_verdict();
    end

    // reset, then the scenarios
    initial
    begin
        repeat (5) @(posedge clock);
        #1;
        rst_b = 1'b1;
        @(posedge clock);
        #1;
        t_strings();
        t_numbers();
        t_faults();
        t_reports();
        give_verdict();
    end
endmodule
